// file: core/mbrtu_pkg.sv
// Summary of operation
// - Start bit, eight data bits, LSB first
// - Optional even or odd parity bit
// - One stop with parity, two without
// - Default format: even parity, one stop
// - Bit rate set by divisor register
// - Slave acts only when protocol enabled
// - First byte compared with own address
// - Address zero: broadcast, acted on, unanswered
// - Silence, address, function, data, CRC, silence
// - Every field character is one byte
// - Receiver watches line also between frames
// - Incomplete frames flagged; bytes up to the last two still delivered
// - Transmit only in reply to query
// - Reply only to own individual address
// - Normal reply: confirmation, data, check field
// - Error reply on failed action
// - Frame check is a CRC
// - Frames bounded by 3.5 character silence
// - Gap over 1.5 characters restarts frame
// - CRC low byte first; mismatch gets silence
// - Exception: function with MSB set, code
package mbrtu_pkg;
  // ****************************************
  // Clock and bit rate
  // ****************************************
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned BAUD_RST  = 19200;
  localparam logic [15:0] DIV_RST   = 16'(CLK_HZ / BAUD_RST);
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_ADDR  = 8'h04;
  localparam logic [7:0]  OFS_DIV   = 8'h08;
  localparam logic [7:0]  OFS_STAT  = 8'h0c;
  localparam logic [2:0]  CTRL_RST  = 3'h2;
  localparam logic [7:0]  ADDR_RST  = 8'h01;
  localparam int          CTRL_EN   = 0;
  localparam int          CTRL_PAR  = 1;
  localparam int          CTRL_ODD  = 2;
  localparam int          ST_FERR   = 0;
  localparam int          ST_CERR   = 1;
  localparam int          ST_PEND   = 2;
  localparam int          ST_INFR   = 3;
  localparam int          ST_TXACT  = 4;
  // ****************************************
  // Framing constants, silences in half bit times
  // ****************************************
  localparam logic [6:0]  T15_HB    = 7'd33;
  localparam logic [6:0]  T35_HB    = 7'd77;
  localparam logic [7:0]  BCAST     = 8'h00;
  localparam logic [7:0]  ADDR_MAX  = 8'hf7;
  localparam logic [7:0]  EXC_FLAG  = 8'h80;
  localparam logic [2:0]  MIN_BYTES = 3'h4;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'ha001;
  localparam logic [3:0]  CHAR_BITS = 4'hb;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        par_en;
    logic        par_odd;
    logic [15:0] div;
  } mbrtu_fmt_t;
  typedef struct packed {
    logic [7:0] data;
    logic       perr;
    logic       ferr;
  } mbrtu_char_t;
  // One byte step of the reflected CRC
  function automatic logic [15:0] mbrtu_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mbrtu_crc_byte
  // Parity bit value for a byte
  function automatic logic mbrtu_par(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : mbrtu_par
endpackage : mbrtu_pkg

// file: core/mbrtu_rx.sv
module mbrtu_rx (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire mbrtu_pkg::mbrtu_fmt_t i_fmt,
  input  wire logic                i_rxd,
  output mbrtu_pkg::mbrtu_char_t   o_char,
  output logic                     o_valid,
  output logic                     o_busy
);
  import mbrtu_pkg::*;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} mbrtu_rx_st_t;
  // ****************************************
  // Line synchroniser and filter
  // ****************************************
  logic [2:0]   sync_ff;
  logic         line_ff;
  // Line level only moves once the last two stages agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync_ff <= 3'h7;
      line_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], i_rxd};
      if (sync_ff[1] == sync_ff[2]) begin
        line_ff <= sync_ff[2];
      end
    end
  end
  // ****************************************
  // Character receiver
  // ****************************************
  mbrtu_rx_st_t st_ff;
  logic [15:0]  cnt_ff;
  logic [2:0]   bit_ff;
  logic [7:0]   sh_ff;
  logic         perr_ff;
  // Mid-bit sampling, runs even between frames
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_ff   <= RX_IDLE;
      cnt_ff  <= 16'h0000;
      bit_ff  <= 3'h0;
      sh_ff   <= 8'h00;
      perr_ff <= 1'b0;
      o_char  <= '0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      if (st_ff != RX_IDLE && cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end else begin
        cnt_ff <= i_fmt.div - 16'h0001;
        case (st_ff)
          RX_IDLE: begin
            if (!line_ff) begin
              st_ff   <= RX_START;
              cnt_ff  <= {1'b0, i_fmt.div[15:1]};
              perr_ff <= 1'b0;
            end
          end
          RX_START: begin
            st_ff  <= line_ff ? RX_IDLE : RX_DATA;
            bit_ff <= 3'h0;
          end
          RX_DATA: begin
            sh_ff  <= {line_ff, sh_ff[7:1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              st_ff <= i_fmt.par_en ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: begin
            perr_ff <= line_ff != mbrtu_par(sh_ff, i_fmt.par_odd);
            st_ff   <= RX_STOP;
          end
          RX_STOP: begin
            // Only the first stop bit is checked; a second one just reads as idle
            o_char  <= '{data: sh_ff, perr: perr_ff, ferr: !line_ff};
            o_valid <= 1'b1;
            st_ff   <= RX_IDLE;
          end
          default: st_ff <= RX_IDLE;
        endcase
      end
    end
  end
  assign o_busy = (st_ff != RX_IDLE);
endmodule : mbrtu_rx

// file: core/mbrtu_tx.sv
module mbrtu_tx (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire mbrtu_pkg::mbrtu_fmt_t i_fmt,
  input  wire logic                  i_start,
  input  wire logic [7:0]            i_data,
  output logic                       o_txd,
  output logic                       o_busy
);
  import mbrtu_pkg::*;
  // ****************************************
  // Character transmitter
  // ****************************************
  logic [10:0] sh_ff;
  logic [3:0]  left_ff;
  logic [15:0] cnt_ff;
  // Always eleven bit times: parity and stop, or two stops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sh_ff   <= 11'h7ff;
      left_ff <= 4'h0;
      cnt_ff  <= 16'h0000;
      o_txd   <= 1'b1;
    end else if (left_ff == 4'h0) begin
      o_txd <= 1'b1;
      if (i_start) begin
        sh_ff   <= {1'b1, i_fmt.par_en ? mbrtu_par(i_data, i_fmt.par_odd) : 1'b1,
                    i_data, 1'b0};
        left_ff <= CHAR_BITS + 4'h1; // Extra tick keeps the last stop bit whole
        cnt_ff  <= 16'h0000;
      end
    end else if (cnt_ff == 16'h0000) begin
      o_txd   <= sh_ff[0];
      sh_ff   <= {1'b1, sh_ff[10:1]};
      cnt_ff  <= i_fmt.div - 16'h0001;
      left_ff <= left_ff - 4'h1;
    end else begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end
  assign o_busy = (left_ff != 4'h0);
endmodule : mbrtu_tx

// file: core/mbrtu_framer.sv
module mbrtu_framer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // RS485 line
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_de,
  // Received query toward the application
  output logic [7:0]       o_rx_byte,
  output logic             o_rx_valid,
  output logic             o_frame_ok,
  output logic             o_frame_err,
  output logic             o_frame_bcast,
  // Response from the application
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_last,
  output logic             o_tx_ready,
  input  wire logic        i_exc_req,
  input  wire logic [7:0]  i_exc_code,
  output logic             o_rsp_pending
);
  import mbrtu_pkg::*;
  typedef enum logic [2:0] {TS_IDLE, TS_ADDR, TS_BODY, TS_EXC1, TS_EXC2,
                            TS_CRCL, TS_CRCH, TS_DONE} mbrtu_tx_st_t;
  // ****************************************
  // Configuration and status registers
  // ****************************************
  logic [2:0]   ctrl_ff;
  logic [7:0]   addr_ff;
  logic [15:0]  div_ff;
  logic         ferr_ff;
  logic         cerr_ff;
  logic         pend_ff;
  logic         in_frame_ff;
  mbrtu_tx_st_t ts_ff;
  mbrtu_fmt_t   fmt;
  logic         en;
  logic         addr_ok;
  logic         set_ferr;
  logic         set_cerr;
  logic         clr_st;
  logic [31:0]  stat;
  assign fmt     = '{par_en: ctrl_ff[CTRL_PAR], par_odd: ctrl_ff[CTRL_ODD], div: div_ff};
  assign en      = ctrl_ff[CTRL_EN];
  assign addr_ok = (addr_ff != BCAST) && (addr_ff <= ADDR_MAX);
  assign clr_st  = i_reg_wr && (i_reg_addr == OFS_STAT);
  assign stat    = {27'h0, ts_ff != TS_IDLE, in_frame_ff, pend_ff, cerr_ff, ferr_ff};
  // Writable settings; reset gives even parity, one stop bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_ff <= CTRL_RST;
      addr_ff <= ADDR_RST;
      div_ff  <= DIV_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        OFS_CTRL: ctrl_ff <= i_reg_wdata[2:0];
        OFS_ADDR: addr_ff <= i_reg_wdata[7:0];
        OFS_DIV:  div_ff  <= i_reg_wdata[15:0];
        default:  ;
      endcase
    end
  end
  // Sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ferr_ff <= 1'b0;
      cerr_ff <= 1'b0;
    end else begin
      ferr_ff <= set_ferr | (ferr_ff & !(clr_st & i_reg_wdata[ST_FERR]));
      cerr_ff <= set_cerr | (cerr_ff & !(clr_st & i_reg_wdata[ST_CERR]));
    end
  end
  // Read data in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_CTRL: o_reg_rdata <= {29'h0, ctrl_ff};
        OFS_ADDR: o_reg_rdata <= {24'h0, addr_ff};
        OFS_DIV:  o_reg_rdata <= {16'h0, div_ff};
        OFS_STAT: o_reg_rdata <= stat;
        default:  o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end
  // ****************************************
  // Character units
  // ****************************************
  mbrtu_char_t rx_char;
  logic        rx_valid;
  logic        rx_busy;
  logic        tx_busy;
  logic        tx_go_ff;
  logic [7:0]  tx_byte_ff;
  mbrtu_rx u_rx (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_fmt   (fmt),
    .i_rxd   (i_rxd),
    .o_char  (rx_char),
    .o_valid (rx_valid),
    .o_busy  (rx_busy)
  );
  mbrtu_tx u_tx (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_fmt   (fmt),
    .i_start (tx_go_ff),
    .i_data  (tx_byte_ff),
    .o_txd   (o_txd),
    .o_busy  (tx_busy)
  );
  // ****************************************
  // Silence timer
  // ****************************************
  logic [14:0] hb_ff;
  logic [6:0]  gap_ff;
  logic        synced_ff;
  logic        gap_long_ff;
  logic        hb_tick;
  assign hb_tick = (hb_ff == 15'h0000);
  // Half bit ticks so 1.5 and 3.5 characters are whole counts
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      hb_ff <= 15'h0000;
    end else begin
      hb_ff <= hb_tick ? (div_ff[15:1] - 15'h0001) : (hb_ff - 15'h0001);
    end
  end
  // Silence since the last line activity, saturating at 3.5 characters
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gap_ff    <= 7'h00;
      synced_ff <= 1'b0;
    end else if (rx_busy || tx_busy || tx_go_ff) begin
      gap_ff <= 7'h00;
    end else if (hb_tick && gap_ff != T35_HB) begin
      gap_ff <= gap_ff + 7'h01;
    end else if (gap_ff == T35_HB) begin
      synced_ff <= 1'b1;
    end
  end
  // Gap is zero at the byte strobe, so remember a long pause until then
  always_ff @(posedge i_clk) begin
    gap_long_ff <= i_rst_b && !rx_valid && (gap_long_ff || gap_ff >= T15_HB);
  end
  // ****************************************
  // Frame receiver
  // ****************************************
  logic [2:0]  nbytes_ff;
  logic        bad_ff;
  logic        match_ff;
  logic [15:0] crc_rx_ff;
  logic [7:0]  func_ff;
  logic [7:0]  p0_ff;
  logic [7:0]  p1_ff;
  logic [1:0]  pcnt_ff;
  logic        new_frame;
  logic        frame_end;
  logic        char_bad;
  logic        good;
  assign new_frame = rx_valid && en && synced_ff && (!in_frame_ff || gap_long_ff);
  assign frame_end = in_frame_ff && gap_ff == T35_HB;
  assign char_bad  = rx_char.perr | rx_char.ferr;
  assign good      = !bad_ff && nbytes_ff >= MIN_BYTES && crc_rx_ff == 16'h0000;
  assign set_cerr  = rx_valid && en && char_bad;
  // A frame cut off by a long gap counts as incomplete
  assign set_ferr  = (frame_end && !good) || (new_frame && in_frame_ff);
  // Address decode, CRC check and two byte delay hiding the check field
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      in_frame_ff   <= 1'b0;
      nbytes_ff     <= 3'h0;
      bad_ff        <= 1'b0;
      match_ff      <= 1'b0;
      o_frame_bcast <= 1'b0;
      crc_rx_ff     <= CRC_INIT;
      func_ff       <= 8'h00;
      p0_ff         <= 8'h00;
      p1_ff         <= 8'h00;
      pcnt_ff       <= 2'h0;
      o_rx_byte     <= 8'h00;
      o_rx_valid    <= 1'b0;
      o_frame_ok    <= 1'b0;
      o_frame_err   <= 1'b0;
    end else begin
      o_rx_valid  <= 1'b0;
      o_frame_ok  <= 1'b0;
      o_frame_err <= 1'b0;
      if (!en) begin
        in_frame_ff <= 1'b0;
      end else if (new_frame) begin
        o_frame_err   <= in_frame_ff && (match_ff || o_frame_bcast);
        in_frame_ff   <= 1'b1;
        nbytes_ff     <= 3'h1;
        bad_ff        <= char_bad;
        match_ff      <= addr_ok && rx_char.data == addr_ff;
        o_frame_bcast <= rx_char.data == BCAST;
        crc_rx_ff     <= mbrtu_crc_byte(CRC_INIT, rx_char.data);
        pcnt_ff       <= 2'h0;
      end else if (rx_valid && in_frame_ff) begin
        crc_rx_ff <= mbrtu_crc_byte(crc_rx_ff, rx_char.data);
        bad_ff    <= bad_ff | char_bad;
        if (nbytes_ff != 3'h7) begin
          nbytes_ff <= nbytes_ff + 3'h1;
        end
        if (nbytes_ff == 3'h1) begin
          func_ff <= rx_char.data;
        end
        p0_ff <= p1_ff;
        p1_ff <= rx_char.data;
        if (pcnt_ff == 2'h2) begin
          o_rx_byte  <= p0_ff;
          o_rx_valid <= match_ff || o_frame_bcast;
        end else begin
          pcnt_ff <= pcnt_ff + 2'h1;
        end
      end else if (frame_end) begin
        in_frame_ff <= 1'b0;
        o_frame_ok  <= good && (match_ff || o_frame_bcast);
        o_frame_err <= !good && (match_ff || o_frame_bcast);
      end
    end
  end
  // ****************************************
  // Response sequencer
  // ****************************************
  logic [15:0] crc_tx_ff;
  logic [7:0]  code_ff;
  logic        exc_ff;
  logic        issue;
  logic [7:0]  nxt_byte;
  assign issue      = !tx_busy && !tx_go_ff;
  assign o_tx_ready = (ts_ff == TS_BODY) && issue;
  assign o_rsp_pending = pend_ff;
  // Byte to send in the current step
  always_comb begin
    case (ts_ff)
      TS_ADDR: nxt_byte = addr_ff;
      TS_BODY: nxt_byte = i_tx_data;
      TS_EXC1: nxt_byte = func_ff | EXC_FLAG;
      TS_EXC2: nxt_byte = code_ff;
      TS_CRCL: nxt_byte = crc_tx_ff[7:0];
      TS_CRCH: nxt_byte = crc_tx_ff[15:8];
      default: nxt_byte = 8'h00;
    endcase
  end
  // Reply permission: only after a good query to our own address
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_ff <= 1'b0;
    end else if (frame_end && good && match_ff && en) begin
      pend_ff <= 1'b1;
    end else if (new_frame || !en || ts_ff == TS_DONE) begin
      pend_ff <= 1'b0;
    end
  end
  // Address, body or exception, then CRC low and high
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ts_ff      <= TS_IDLE;
      crc_tx_ff  <= CRC_INIT;
      code_ff    <= 8'h00;
      exc_ff     <= 1'b0;
      tx_go_ff   <= 1'b0;
      tx_byte_ff <= 8'h00;
      o_de       <= 1'b0;
    end else begin
      tx_go_ff <= 1'b0;
      case (ts_ff)
        TS_IDLE: begin
          if (pend_ff && !in_frame_ff && (i_exc_req || i_tx_valid)) begin
            ts_ff     <= TS_ADDR;
            exc_ff    <= i_exc_req;
            code_ff   <= i_exc_code;
            crc_tx_ff <= CRC_INIT;
            o_de      <= 1'b1;
          end
        end
        TS_DONE: begin
          if (issue) begin
            ts_ff <= TS_IDLE;
            o_de  <= 1'b0;
          end
        end
        default: begin
          if (issue && (ts_ff != TS_BODY || i_tx_valid)) begin
            tx_go_ff   <= 1'b1;
            tx_byte_ff <= nxt_byte;
            if (ts_ff != TS_CRCL && ts_ff != TS_CRCH) begin
              crc_tx_ff <= mbrtu_crc_byte(crc_tx_ff, nxt_byte);
            end
            case (ts_ff)
              TS_ADDR: ts_ff <= exc_ff ? TS_EXC1 : TS_BODY;
              TS_BODY: ts_ff <= i_tx_last ? TS_CRCL : TS_BODY;
              TS_EXC1: ts_ff <= TS_EXC2;
              TS_EXC2: ts_ff <= TS_CRCL;
              TS_CRCL: ts_ff <= TS_CRCH;
              default: ts_ff <= TS_DONE;
            endcase
          end
        end
      endcase
    end
  end
endmodule : mbrtu_framer

// file: tb/mbrtu_chk.sv
module mbrtu_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_txd,
  input wire logic        o_de,
  input wire logic        o_rx_valid,
  input wire logic        o_frame_ok,
  input wire logic        o_frame_err,
  input wire logic        o_frame_bcast,
  input wire logic        o_rsp_pending
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ****************************************
  // Line driver and reply
  // ****************************************
  a_line_idle_mark: assert property (!o_de |-> o_txd)
    else $error("line low while driver off");
  a_reply_cause: assert property ($rose(o_de) |-> $past(o_rsp_pending))
    else $error("driver on without pending query");
  a_bcast_silent: assert property (o_frame_bcast |-> !o_de)
    else $error("driver on after broadcast");
  a_bcast_no_pend: assert property (o_frame_bcast |-> !o_rsp_pending)
    else $error("broadcast left reply pending");
  // ****************************************
  // Receive side
  // ****************************************
  // Bytes are a character apart, so eight quiet cycles is a safe floor
  a_rx_spaced: assert property (o_rx_valid |=> !o_rx_valid [*8])
    else $error("byte strobes too close");
  a_end_once: assert property (o_frame_ok |=> !o_frame_ok)
    else $error("frame end pulse too long");
  a_ok_err_excl: assert property (!(o_frame_ok && o_frame_err))
    else $error("frame both good and bad");
  a_err_no_reply: assert property (o_frame_err |=> !o_rsp_pending)
    else $error("errored frame awaits reply");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  c_good: cover property (o_frame_ok && !o_frame_bcast);
  c_bcast: cover property (o_frame_ok && o_frame_bcast);
  c_bad: cover property (o_frame_err);
  c_reply: cover property ($rose(o_de));
endmodule : mbrtu_chk

// file: tb/mbrtu_master_model.sv
module mbrtu_master_model (
  input  wire logic                  i_clk,
  input  wire mbrtu_pkg::mbrtu_fmt_t i_fmt,
  input  wire logic                  i_line,
  output logic                       o_line
);
  timeunit 1ns;
  timeprecision 100ps;
  import mbrtu_pkg::*;
  logic [7:0] rx_q[$];
  int         bad_cnt;
  // Master holds the bus at mark level between characters
  initial begin
    o_line  = 1'b1;
    bad_cnt = 0;
  end
  // One bit time on the line
  task automatic put(input logic v);
    @(posedge i_clk);
    o_line <= v;
    repeat (i_fmt.div - 1) @(posedge i_clk);
  endtask : put
  // Start, data LSB first, parity, stop bits
  task automatic send_byte(input logic [7:0] b);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    if (i_fmt.par_en) put((^b) ^ i_fmt.par_odd);
    put(1'b1);
    if (!i_fmt.par_en) put(1'b1);
  endtask : send_byte
  // Reply decoder, sampling mid-bit; glitches shorter than half a bit dropped
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge i_line);
      repeat (i_fmt.div / 2) @(posedge i_clk);
      if (i_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (i_fmt.div) @(posedge i_clk);
          d[i] = i_line;
        end
        if (i_fmt.par_en) begin
          repeat (i_fmt.div) @(posedge i_clk);
          if (i_line !== ((^d) ^ i_fmt.par_odd)) bad_cnt++;
        end
        repeat (i_fmt.div) @(posedge i_clk);
        if (i_line !== 1'b1) bad_cnt++;
        rx_q.push_back(d);
      end
    end
  end
endmodule : mbrtu_master_model

// file: tb/tb_mbrtu_framer.sv
module tb_mbrtu_framer;
  timeunit 1ns;
  timeprecision 100ps;
  import mbrtu_pkg::*;
  typedef logic [7:0] mbrtu_bq_t[$];
  localparam int DIV = 16;
  localparam int SIL = 900;
  logic        clk, rst_b, reg_wr, reg_rd, rxd, txd, de, rx_valid, frame_ok;
  logic        frame_err, frame_bcast, tx_valid, tx_last, tx_ready, exc_req, rsp_pending;
  logic [7:0]  reg_addr, rx_byte, tx_data, exc_code;
  logic [31:0] reg_wdata, reg_rdata, v;
  mbrtu_fmt_t  mfmt;
  mbrtu_bq_t   got_q;
  int          error_cnt, checks, cyc, ok_n, err_n, ok0, err0;
  mbrtu_framer DUT (.i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_rxd(rxd), .o_txd(txd), .o_de(de), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid),
    .o_frame_ok(frame_ok), .o_frame_err(frame_err), .o_frame_bcast(frame_bcast),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
    .i_exc_req(exc_req), .i_exc_code(exc_code), .o_rsp_pending(rsp_pending));
  mbrtu_master_model m (.i_clk(clk), .i_fmt(mfmt), .i_line(txd), .o_line(rxd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watch outputs; ceiling cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) got_q.push_back(rx_byte);
    if (frame_ok === 1'b1) ok_n++;
    if (frame_err === 1'b1) err_n++;
    if (cyc == 95000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk32
  task automatic chkq(input mbrtu_bq_t got, input mbrtu_bq_t exp, input string msg);
    checks++;
    if (got.size() != exp.size() || (got == exp) !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s got %p exp %p", $time, msg, got, exp);
    end
  endtask : chkq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  // Own CRC model, low byte appended first
  function automatic mbrtu_bq_t with_crc(input mbrtu_bq_t q, input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    c ^= {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction : with_crc
  task automatic send(input mbrtu_bq_t q, input logic bad);
    mbrtu_bq_t f;
    f = with_crc(q, bad);
    got_q.delete();
    ok0  = ok_n;
    err0 = err_n;
    foreach (f[i]) m.send_byte(f[i]);
    repeat (SIL) @(posedge clk);
  endtask : send
  // Application reply; body handed over on ready, or an exception
  task automatic reply(input mbrtu_bq_t q, input logic exc, input logic [7:0] code);
    int n;
    m.rx_q.delete();
    @(posedge clk);
    if (exc) begin
      exc_req  <= 1'b1;
      exc_code <= code;
      @(posedge clk);
      exc_req  <= 1'b0;
    end else begin
      foreach (q[i]) begin
        tx_data  <= q[i];
        tx_valid <= 1'b1;
        tx_last  <= (i == q.size() - 1);
        n = 0;
        do @(posedge clk); while (tx_ready !== 1'b1 && n++ < 5000);
      end
      tx_valid <= 1'b0;
    end
    n = 0;
    while (de !== 1'b1 && n++ < 50) @(posedge clk);
    while (de === 1'b1 && n++ < 20000) @(posedge clk);
    repeat (2 * DIV) @(posedge clk);
  endtask : reply
  initial begin
    static logic [2:0] fm [3] = '{3'h3, 3'h7, 3'h1};
    {rst_b, reg_wr, reg_rd, tx_valid, tx_last, exc_req} = '0;
    {reg_addr, reg_wdata, tx_data, exc_code, error_cnt, checks, cyc, ok_n, err_n} = '0;
    mfmt = '{par_en: 1'b1, par_odd: 1'b0, div: 16'(DIV)};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values and read-back
    rd(OFS_CTRL, v); chk32(v, 32'h2, "ctrl reset");
    rd(OFS_ADDR, v); chk32(v, 32'h1, "addr reset");
    rd(OFS_DIV, v); chk32(v, {16'h0, DIV_RST}, "div reset");
    rd(8'h10, v); chk32(v, 32'h0, "unmapped");
    wr(OFS_DIV, DIV);
    wr(OFS_ADDR, 32'h5);
    rd(OFS_DIV, v); chk32(v, DIV, "div");
    // Unicast exchange in every character format
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL, {29'h0, fm[k]});
      mfmt.par_en  = fm[k][1];
      mfmt.par_odd = fm[k][2];
      repeat (k == 0 ? 3 * SIL : SIL) @(posedge clk);
      send('{8'h05, 8'h03, 8'(8'h11 + k)}, 1'b0);
      chkq(got_q, '{8'h03, 8'(8'h11 + k)}, "query bytes");
      chk32(ok_n, ok0 + 1, "frame ok");
      chk32(rsp_pending, 1, "pending");
      reply('{8'h03, 8'(8'h40 + k)}, 1'b0, 8'h00);
      chkq(m.rx_q, with_crc('{8'h05, 8'h03, 8'(8'h40 + k)}, 1'b0), "reply");
      chk32(m.bad_cnt, 0, "char format");
    end
    // Exception reply
    send('{8'h05, 8'h04, 8'h00, 8'h01}, 1'b0);
    reply('{}, 1'b1, 8'h02);
    chkq(m.rx_q, with_crc('{8'h05, 8'h84, 8'h02}, 1'b0), "exception");
    // Broadcast acted on, never answered
    send('{8'h00, 8'h06, 8'h22}, 1'b0);
    chkq(got_q, '{8'h06, 8'h22}, "bcast bytes");
    chk32(frame_bcast, 1, "bcast flag");
    chk32(rsp_pending, 0, "bcast pending");
    reply('{}, 1'b1, 8'h01);
    chk32(m.rx_q.size(), 0, "bcast reply");
    // Foreign address ignored
    send('{8'h07, 8'h03, 8'h11}, 1'b0);
    chkq(got_q, '{}, "foreign bytes");
    chk32(ok_n + err_n, ok0 + err0, "foreign end");
    // Bad check value: error, no reply, sticky status cleared by writing one
    send('{8'h05, 8'h03, 8'h11}, 1'b1);
    chk32(err_n, err0 + 1, "crc err");
    chk32(rsp_pending, 0, "crc pending");
    rd(OFS_STAT, v); chk32(v[ST_FERR], 1, "stat set");
    wr(OFS_STAT, 32'h1);
    rd(OFS_STAT, v); chk32(v[ST_FERR], 0, "stat clear");
    // Too short a frame
    err0 = err_n;
    m.send_byte(8'h05);
    m.send_byte(8'h03);
    repeat (SIL) @(posedge clk);
    chk32(err_n, err0 + 1, "short frame");
    // Gap in mid-frame restarts at the next byte
    m.send_byte(8'h05);
    repeat (3 * 11 * DIV / 2 + 4 * DIV) @(posedge clk);
    send('{8'h05, 8'h05, 8'h77}, 1'b0);
    chk32(err_n, err0 + 1, "gap err");
    chk32(ok_n, ok0 + 1, "gap restart");
    reply('{8'h05}, 1'b0, 8'h00);
    chkq(m.rx_q, with_crc('{8'h05, 8'h05}, 1'b0), "gap reply");
    // Protocol disabled: nothing seen
    wr(OFS_CTRL, 32'h2);
    send('{8'h05, 8'h03, 8'h11}, 1'b0);
    chkq(got_q, '{}, "disabled bytes");
    chk32(ok_n + err_n, ok0 + err0, "disabled end");
    end_sim();
  end
endmodule : tb_mbrtu_framer
bind mbrtu_framer mbrtu_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_txd(o_txd), .o_de(o_de), .o_rx_valid(o_rx_valid),
  .o_frame_ok(o_frame_ok), .o_frame_err(o_frame_err), .o_frame_bcast(o_frame_bcast),
  .o_rsp_pending(o_rsp_pending));
